// ===== pdu_pkg.sv
package pdu_pkg;

    localparam logic [15:0] ADDR_CTL_DUTYA_HI = 16'hffa0;
    localparam logic [15:0] ADDR_DUTYA_LO     = 16'hffa1;
    localparam logic [15:0] ADDR_CNT_DUTYB_HI = 16'hffa6;
    localparam logic [15:0] ADDR_CNT_DUTYB_LO = 16'hffa7;
    localparam logic [15:0] ADDR_HALT_HI      = 16'hff86;
    localparam logic [15:0] ADDR_HALT_LO      = 16'hff87;

    localparam logic [7:0]  CTL_RST        = 8'h30;
    localparam logic [7:0]  CTL_FIXED_ONES = 8'h30;
    localparam logic [15:0] HALT_RST       = 16'h3fff;
    localparam logic [15:0] DUTY_RST       = 16'hffff;
    localparam logic [13:0] CNT_RST        = 14'h0000;
    localparam logic        BANK_RST       = 1'b1;
    localparam logic [7:0]  UNMAPPED_READ  = 8'hff;

    localparam int CTL_TEST_BIT   = 7;
    localparam int CTL_HALT_BIT   = 6;
    localparam int CTL_OUT_B_BIT  = 3;
    localparam int CTL_OUT_A_BIT  = 2;
    localparam int CTL_INV_BIT    = 1;
    localparam int CTL_RES_BIT    = 0;
    localparam int DUTY_CARRIER_BIT = 1;
    localparam int DUTY_BANK_BIT  = 0;
    localparam int HALT_PWM_BIT   = 11;

    localparam logic [15:0] RANGE_LO_SHORT = 16'h0401;
    localparam logic [15:0] RANGE_HI_SHORT = 16'hfffd;
    localparam logic [15:0] RANGE_LO_LONG  = 16'h0103;
    localparam logic [15:0] RANGE_HI_LONG  = 16'hffff;

endpackage

// ===== pdu_rst_sync.sv
`timescale 1ns/1ps
module pdu_rst_sync
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    output logic      rst_sync_n
);
    logic stage1;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1     <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            stage1     <= 1'b1;
            rst_sync_n <= stage1;
        end
    end
endmodule // pdu_rst_sync

// ===== pdu_chan.sv
`timescale 1ns/1ps
module pdu_chan
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [13:0] cnt,
    input  wire logic [15:0] duty,
    input  wire logic        invert,
    input  wire logic        enable,
    output logic             pin
);
    wire logic [13:0] da    = duty[15:2];
    wire logic        carrier_select = duty[pdu_pkg::DUTY_CARRIER_BIT];
    // Long carrier: 256-step base cycle, 64 base cycles per conversion
    wire logic        ext_l = {2'b00, cnt[13:8]} < {2'b00, da[5:0]};
    wire logic        low_l = {1'b0, cnt[7:0]} < ({1'b0, da[13:6]} + {8'h00, ext_l});
    // Short carrier: 64-step base cycle, 256 base cycles per conversion
    wire logic        ext_s = cnt[13:6] < da[7:0];
    wire logic        low_s = {1'b0, cnt[5:0]} < ({1'b0, da[13:8]} + {6'h00, ext_s});
    wire logic        above = carrier_select ? (duty > pdu_pkg::RANGE_HI_LONG)
                                             : (duty > pdu_pkg::RANGE_HI_SHORT);
    wire logic        below = carrier_select ? (duty < pdu_pkg::RANGE_LO_LONG)
                                             : (duty < pdu_pkg::RANGE_LO_SHORT);
    wire logic        in_range = !above && !below;
    // Flat output outside range: high above the range, low below it
    wire logic        level = in_range ? !(carrier_select ? low_l : low_s)
                                       : above;
    wire logic        next_pin = enable && (level ^ invert);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pin <= 1'b0;
        else
            pin <= next_pin;
    end

    a_pin_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !enable |=> !pin) else $error("pin driven while disabled");
    a_flat_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (enable && below && !invert) [*2] |=> !pin) else $error("out of range not flat");
    a_phase_inv: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (enable && invert && below) |=> pin) else $error("inverted phase wrong");
    c_modulating: cover property (@(posedge clk_sys) disable iff (!rst_n)
        enable && in_range ##1 pin ##1 !pin);
endmodule // pdu_chan

// ===== pdu_top.sv
`timescale 1ns/1ps
module pdu_top
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        sw_standby,
    input  wire logic        hw_standby,
    input  wire logic [15:0] bus_addr,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    output logic             pwm_pin_a,
    output logic             pwm_pin_b
);
    logic        rst_q_n;
    logic [7:0]  pwm_control;
    logic [15:0] module_halt_control;
    logic [15:0] channel_a_duty;
    logic [15:0] channel_b_duty;
    logic [13:0] time_base_counter;
    logic        bank_sel;
    logic        res_phase;
    logic [7:0]  hold_latch;

    pdu_rst_sync u_rst
    (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .rst_sync_n (rst_q_n)
    );

    // Block-wide clear sources
    wire logic pwm_module_halt = module_halt_control[pdu_pkg::HALT_PWM_BIT];
    wire logic blk_clr         = pwm_module_halt || sw_standby || hw_standby;
    wire logic counter_halt_ctl  = pwm_control[pdu_pkg::CTL_HALT_BIT];
    wire logic chan_b_out_enable = pwm_control[pdu_pkg::CTL_OUT_B_BIT];
    wire logic chan_a_out_enable = pwm_control[pdu_pkg::CTL_OUT_A_BIT];
    wire logic output_invert     = pwm_control[pdu_pkg::CTL_INV_BIT];
    wire logic resolution_select = pwm_control[pdu_pkg::CTL_RES_BIT];

    // Address decode; the duty and counter addresses are steered by the bank bit, the halt addresses are not
    wire logic at_a0 = bus_addr == pdu_pkg::ADDR_CTL_DUTYA_HI;
    wire logic at_a1 = bus_addr == pdu_pkg::ADDR_DUTYA_LO;
    wire logic at_b0 = bus_addr == pdu_pkg::ADDR_CNT_DUTYB_HI;
    wire logic at_b1 = bus_addr == pdu_pkg::ADDR_CNT_DUTYB_LO;
    wire logic sel_ctl   = at_a0 && bank_sel;
    wire logic sel_da_hi = at_a0 && !bank_sel;
    wire logic sel_da_lo = at_a1 && !bank_sel;
    wire logic sel_db_hi = at_b0 && !bank_sel;
    wire logic sel_db_lo = at_b1 && !bank_sel;
    wire logic sel_cn_hi = at_b0 && bank_sel;
    wire logic sel_cn_lo = at_b1 && bank_sel;
    wire logic sel_mh_hi = bus_addr == pdu_pkg::ADDR_HALT_HI;
    wire logic sel_mh_lo = bus_addr == pdu_pkg::ADDR_HALT_LO;
    wire logic sel_upper = sel_da_hi || sel_db_hi || sel_cn_hi;
    wire logic sel_lower = sel_da_lo || sel_db_lo || sel_cn_lo;

    // Counter in the bus view: low byte holds bits 8..13 reversed
    wire logic [15:0] cnt_view = {time_base_counter[7:0],
                                  time_base_counter[8], time_base_counter[9],
                                  time_base_counter[10], time_base_counter[11],
                                  time_base_counter[12], time_base_counter[13],
                                  1'b1, bank_sel};
    wire logic [15:0] db_view  = {channel_b_duty[15:1], bank_sel};
    wire logic [15:0] da_view  = {channel_a_duty[15:1], 1'b1};

    // One latch shared by both duty registers and the counter, so interleaving corrupts
    wire logic [15:0] word_in  = {hold_latch, bus_wdata};
    wire logic        wr_upper = bus_wr && sel_upper;
    wire logic        wr_lower = bus_wr && sel_lower;
    wire logic        rd_upper = bus_rd && sel_upper;
    wire logic        rd_lower = bus_rd && sel_lower;

    wire logic [15:0] upper_src = sel_da_hi ? da_view : (sel_db_hi ? db_view : cnt_view);
    wire logic [7:0]  next_hold = wr_upper ? bus_wdata
                                : rd_upper ? upper_src[7:0]
                                : hold_latch;

    wire logic [7:0] rd_val = sel_ctl   ? (pwm_control | pdu_pkg::CTL_FIXED_ONES)
                            : sel_upper ? upper_src[15:8]
                            : sel_lower ? hold_latch
                            : sel_mh_hi ? module_halt_control[15:8]
                            : sel_mh_lo ? module_halt_control[7:0]
                            : pdu_pkg::UNMAPPED_READ;

    // Control register; bits 5:4 forced, test bit only stored
    wire logic [7:0] next_ctl = blk_clr ? pdu_pkg::CTL_RST
                              : (bus_wr && sel_ctl)
                              ? (bus_wdata | pdu_pkg::CTL_FIXED_ONES)
                              : pwm_control;

    // Halt register only cleared by chip reset or hardware standby
    wire logic [15:0] next_halt = hw_standby ? pdu_pkg::HALT_RST
                                : (bus_wr && sel_mh_hi)
                                ? {bus_wdata, module_halt_control[7:0]}
                                : (bus_wr && sel_mh_lo)
                                ? {module_halt_control[15:8], bus_wdata}
                                : module_halt_control;

    wire logic [15:0] next_da = blk_clr ? pdu_pkg::DUTY_RST
                              : (wr_lower && sel_da_lo) ? {word_in[15:1], 1'b1}
                              : channel_a_duty;
    wire logic [15:0] next_db = blk_clr ? pdu_pkg::DUTY_RST
                              : (wr_lower && sel_db_lo) ? word_in
                              : channel_b_duty;
    wire logic        next_bank = blk_clr ? pdu_pkg::BANK_RST
                                : (wr_lower && at_b1) ? bus_wdata[pdu_pkg::DUTY_BANK_BIT]
                                : bank_sel;

    // Counter: slow resolution steps every second clock
    wire logic        cnt_run  = !counter_halt_ctl && !blk_clr;
    wire logic        cnt_step = cnt_run && (!resolution_select || res_phase);
    wire logic [13:0] cnt_wr   = {word_in[2], word_in[3], word_in[4], word_in[5],
                                  word_in[6], word_in[7], word_in[15:8]};
    wire logic [13:0] next_cnt = !cnt_run ? pdu_pkg::CNT_RST
                               : (wr_lower && sel_cn_lo) ? cnt_wr
                               : cnt_step ? time_base_counter + 14'h0001
                               : time_base_counter;
    wire logic        next_phase = cnt_run && resolution_select && !res_phase;

    always_ff @(posedge clk_sys or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            pwm_control         <= pdu_pkg::CTL_RST;
            module_halt_control <= pdu_pkg::HALT_RST;
            channel_a_duty      <= pdu_pkg::DUTY_RST;
            channel_b_duty      <= pdu_pkg::DUTY_RST;
            bank_sel            <= pdu_pkg::BANK_RST;
            time_base_counter   <= pdu_pkg::CNT_RST;
            res_phase           <= 1'b0;
            hold_latch          <= 8'h00;
            bus_rdata           <= 8'h00;
        end
        else
        begin
            pwm_control         <= next_ctl;
            module_halt_control <= next_halt;
            channel_a_duty      <= next_da;
            channel_b_duty      <= next_db;
            bank_sel            <= next_bank;
            time_base_counter   <= next_cnt;
            res_phase           <= next_phase;
            hold_latch          <= next_hold;
            bus_rdata           <= bus_rd ? rd_val : bus_rdata;
        end
    end

    // Carrier length and range live per channel in duty bit 1
    pdu_chan u_chan_a
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_q_n),
        .cnt     (time_base_counter),
        .duty    (da_view),
        .invert  (output_invert),
        .enable  (chan_a_out_enable && !blk_clr),
        .pin     (pwm_pin_a)
    );

    pdu_chan u_chan_b
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_q_n),
        .cnt     (time_base_counter),
        .duty    (channel_b_duty),
        .invert  (output_invert),
        .enable  (chan_b_out_enable && !blk_clr),
        .pin     (pwm_pin_b)
    );

    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_q_n);

    a_ctl_fixed: assert property (pwm_control[5:4] == 2'b11)
        else $error("control fixed bits not one");
    a_clr_ctl: assert property (blk_clr |=> pwm_control == pdu_pkg::CTL_RST)
        else $error("control not cleared");
    a_halt_cnt: assert property (counter_halt_ctl |=> time_base_counter == 14'h0000)
        else $error("halted counter moved");
    a_stop_cnt: assert property (pwm_module_halt |=> cnt_view[15:2] == 14'h0000)
        else $error("stopped counter not cleared");
    a_upper_wr: assert property (wr_upper |=> hold_latch == $past(bus_wdata)
        && $stable(channel_b_duty)) else $error("upper write touched register");
    a_lower_wr: assert property ((wr_upper && sel_db_hi) ##1 (wr_lower && sel_db_lo && !blk_clr)
        |=> channel_b_duty == {$past(bus_wdata, 2), $past(bus_wdata)}) else $error("word commit");
    a_upper_rd: assert property ((rd_upper ##1 (rd_lower && !bus_wr)) |=>
        bus_rdata == $past(upper_src[7:0], 2)) else $error("lower read not latched");
    a_res_slow: assert property ((cnt_step && resolution_select) |=>
        !cnt_step || !resolution_select) else $error("slow resolution stepped twice");
    a_halt_keep: assert property ((sw_standby && !hw_standby && !bus_wr) |=>
        $stable(module_halt_control)) else $error("halt lost in software standby");
    a_da_lsb: assert property (channel_a_duty[0])
        else $error("duty A bit 0 cleared");

    c_word_write: cover property (wr_upper ##1 wr_lower);
    c_word_read: cover property (rd_upper ##1 rd_lower);
    c_bank_flip: cover property (bank_sel ##1 !bank_sel);
endmodule // pdu_top

// ===== pdu_bus_master.sv
`timescale 1ns/1ps
module pdu_bus_master
(
    input  wire logic        clk_sys,
    input  wire logic [7:0]  bus_rdata,
    output logic      [15:0] bus_addr,
    output logic             bus_wr,
    output logic             bus_rd,
    output logic      [7:0]  bus_wdata
);
    initial
    begin
        bus_addr  = 16'h0000;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_wdata = 8'h00;
    end

    // Stale data is scrambled so it cannot pass for a fresh byte
    task automatic wr8(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(negedge clk_sys);
        bus_wr    <= 1'b0;
        bus_wdata <= ~d;
    endtask

    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(negedge clk_sys);
        bus_rd   <= 1'b0;
        d = bus_rdata;
    endtask

    // Whole words only, upper byte first, on back-to-back edges
    task automatic wr16(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        bus_addr  <= a;
        bus_wdata <= d[15:8];
        bus_wr    <= 1'b1;
        @(negedge clk_sys);
        bus_addr  <= a + 16'h0001;
        bus_wdata <= d[7:0];
        @(negedge clk_sys);
        bus_wr    <= 1'b0;
        bus_wdata <= ~d[7:0];
    endtask

    task automatic rd16(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(negedge clk_sys);
        d[15:8]  = bus_rdata;
        bus_addr <= a + 16'h0001;
        @(negedge clk_sys);
        d[7:0]   = bus_rdata;
        bus_rd   <= 1'b0;
    endtask
endmodule // pdu_bus_master

// ===== pwm_dac_control_access_test.sv
`timescale 1ns/1ps
module pwm_dac_control_access_test;
    localparam logic [15:0] A_CTL = pdu_pkg::ADDR_CTL_DUTYA_HI;
    localparam logic [15:0] A_CNT = pdu_pkg::ADDR_CNT_DUTYB_HI;
    localparam logic [15:0] A_HLT = pdu_pkg::ADDR_HALT_HI;

    logic        clk_sys;
    logic        rst_n;
    logic        sw_standby;
    logic        hw_standby;
    logic [15:0] bus_addr;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  bus_wdata;
    logic [7:0]  bus_rdata;
    logic        pwm_pin_a;
    logic        pwm_pin_b;
    int          failures;
    int          check_count;
    int          cycles;
    int          ca;
    int          cb;
    logic [15:0] r16;
    logic [7:0]  r8;

    pdu_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .sw_standby(sw_standby),
        .hw_standby(hw_standby), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .pwm_pin_a(pwm_pin_a),
        .pwm_pin_b(pwm_pin_b));
    pdu_bus_master bm (.clk_sys(clk_sys), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Budget covers both full conversion measurements with margin
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            failures++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic r8c(input string what, input logic [15:0] a, input logic [7:0] exp);
        bm.rd8(a, r8);
        check(what, {8'h00, r8}, {8'h00, exp});
    endtask

    task automatic r16c(input string what, input logic [15:0] a, input logic [15:0] exp);
        bm.rd16(a, r16);
        check(what, r16, exp);
    endtask

    task automatic meas(input int n, input logic lvl);
        ca = 0;
        cb = 0;
        repeat (n)
        begin
            @(negedge clk_sys);
            ca += (pwm_pin_a === lvl) ? 1 : 0;
            cb += (pwm_pin_b === lvl) ? 1 : 0;
        end
    endtask

    // Settling cycles skip the pin register latency
    task automatic flat(input logic lvl);
        repeat (8) @(negedge clk_sys);
        meas(600, lvl);
        check("flat_a", ca[15:0], 16'd600);
        check("flat_b", cb[15:0], 16'd600);
    endtask

    initial
    begin
        rst_n = 1'b0;
        sw_standby = 1'b0;
        hw_standby = 1'b0;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        r8c("halt_hi", A_HLT, 8'h3f);
        r8c("halt_lo", A_HLT + 16'h0001, 8'hff);
        bm.wr8(A_HLT, 8'h37);
        r8c("control", A_CTL, 8'h30);
        bm.wr8(A_CTL, 8'h00);
        r8c("control_fixed", A_CTL, 8'h30);
        bm.wr8(A_CTL, 8'hcf);
        r8c("control_all", A_CTL, 8'hff);
        bm.wr8(A_CTL, 8'h40);
        r16c("counter_halted", A_CNT, 16'h0003);
        bm.wr16(A_CNT, 16'h0002);
        bm.wr16(A_CNT, 16'h1234);
        r16c("duty_b", A_CNT, 16'h1234);
        bm.wr16(A_CTL, 16'h5678);
        r16c("duty_a", A_CTL, 16'h5679);
        bm.wr8(A_CNT, 8'hab);
        r8c("duty_b_hi", A_CNT, 8'h12);
        bm.wr8(A_CNT + 16'h0001, 8'h56);
        r16c("latch_shared", A_CNT, 16'h3456);
        bm.wr16(A_CTL, 16'h0001);
        bm.wr16(A_CNT, 16'h0003);
        r8c("bank_control", A_CTL, 8'h70);
        bm.wr8(A_CTL, 8'h02);
        flat(1'b0);
        bm.wr8(A_CTL, 8'h0c);
        flat(1'b0);
        bm.wr8(A_CTL, 8'h0e);
        flat(1'b1);
        bm.wr16(A_CNT, 16'h5a87);
        r16c("counter_run", A_CNT, 16'h5b87);
        bm.wr16(A_CNT, 16'h0002);
        bm.wr16(A_CTL, 16'h8001);
        bm.wr16(A_CNT, 16'h4003);
        bm.wr8(A_CTL, 8'h0c);
        repeat (300) @(negedge clk_sys);
        meas(16384, 1'b0);
        check("low_time_a", ca[15:0], 16'h2000);
        check("low_time_b", cb[15:0], 16'h1000);
        bm.wr8(A_CTL, 8'h0f);
        repeat (300) @(negedge clk_sys);
        meas(32768, 1'b1);
        check("high_time_a", ca[15:0], 16'h4000);
        check("high_time_b", cb[15:0], 16'h2000);
        bm.wr8(A_HLT, 8'h3f);
        repeat (4) @(negedge clk_sys);
        check("pins_stopped", {14'h0000, pwm_pin_a, pwm_pin_b}, 16'h0000);
        bm.wr8(A_HLT, 8'h37);
        r8c("control_stop", A_CTL, 8'h30);
        bm.wr8(A_CTL, 8'h0c);
        @(negedge clk_sys);
        sw_standby = 1'b1;
        @(negedge clk_sys);
        sw_standby = 1'b0;
        r8c("control_standby", A_CTL, 8'h30);
        r8c("halt_kept", A_HLT, 8'h37);
        @(negedge clk_sys);
        hw_standby = 1'b1;
        @(negedge clk_sys);
        hw_standby = 1'b0;
        r8c("halt_reload", A_HLT, 8'h3f);
        stop_test();
    end
endmodule // pwm_dac_control_access_test
